// >>> hw/sfrp_pkg.sv
// Constants and decode helpers for the read-parameter register block
package sfrp_pkg;

  // ==========================================================
  // Register layout and value after reset
  localparam logic [7:0] RP_RESET    = 8'h00;
  localparam int         PIN_SEL_BIT = 7;
  localparam int         DUMMY_MSB   = 6;
  localparam int         DUMMY_LSB   = 3;
  localparam int         WRAP_BIT    = 2;
  localparam int         BURST_MSB   = 1;
  localparam int         BURST_LSB   = 0;

  // ==========================================================
  // Command codes
  localparam logic [7:0] OPC_SET_NV      = 8'h65;
  localparam logic [7:0] OPC_SET_VOL_A   = 8'hC0;
  localparam logic [7:0] OPC_SET_VOL_B   = 8'h63;
  localparam logic [7:0] OPC_FAST        = 8'h0B;
  localparam logic [7:0] OPC_FAST_DTR    = 8'h0D;
  localparam logic [7:0] OPC_DUAL_OUT    = 8'h3B;
  localparam logic [7:0] OPC_DUAL_IO     = 8'hBB;
  localparam logic [7:0] OPC_DUAL_IO_DTR = 8'hBD;
  localparam logic [7:0] OPC_QUAD_OUT    = 8'h6B;
  localparam logic [7:0] OPC_QUAD_IO     = 8'hEB;
  localparam logic [7:0] OPC_QUAD_IO_DTR = 8'hED;
  localparam logic [7:0] OPC_UID_READ    = 8'h4B;
  localparam logic [7:0] OPC_INFO_READ   = 8'h68;

  // ==========================================================
  // Default dummy counts, in serial-clock periods
  localparam logic [3:0] DUMMY_DEF_SPI   = 4'h8;
  localparam logic [3:0] DUMMY_DEF_QPI   = 4'h6;
  localparam logic [3:0] DUMMY_DEF_DUAL  = 4'h4;
  localparam logic [3:0] DUMMY_DEF_QUAD  = 4'h6;

  // ==========================================================
  // Frame bit counts, in serial-clock periods
  localparam logic [5:0] CYC_BYTE_SPI = 6'h08;
  localparam logic [5:0] CYC_BYTE_QPI = 6'h02;
  localparam logic [5:0] CYC_ADDR_X1  = 6'h18;
  localparam logic [5:0] CYC_ADDR_X2  = 6'h0C;
  localparam logic [5:0] CYC_ADDR_X4  = 6'h06;
  localparam logic [5:0] CYC_ADDR_X8  = 6'h03;

  // Read commands this block steers
  function automatic logic is_read(input logic [7:0] opc);
    is_read = (opc == OPC_FAST) || (opc == OPC_FAST_DTR) ||
              (opc == OPC_DUAL_OUT) || (opc == OPC_DUAL_IO) ||
              (opc == OPC_DUAL_IO_DTR) || (opc == OPC_QUAD_OUT) ||
              (opc == OPC_QUAD_IO) || (opc == OPC_QUAD_IO_DTR) ||
              (opc == OPC_UID_READ) || (opc == OPC_INFO_READ);
  endfunction

  // Default dummy count per command and mode
  function automatic logic [3:0] default_dummy(input logic [7:0] opc,
                                               input logic       qpi);
    case (opc)
      OPC_DUAL_IO, OPC_DUAL_IO_DTR: default_dummy = DUMMY_DEF_DUAL;
      OPC_QUAD_IO, OPC_QUAD_IO_DTR: default_dummy = DUMMY_DEF_QUAD;
      OPC_DUAL_OUT, OPC_QUAD_OUT:   default_dummy = DUMMY_DEF_SPI;
      default: default_dummy = qpi ? DUMMY_DEF_QPI : DUMMY_DEF_SPI;
    endcase
  endfunction

  // Address periods; double-rate forms move twice the bits a period
  function automatic logic [5:0] addr_cycles(input logic [7:0] opc,
                                             input logic       qpi);
    case (opc)
      OPC_DUAL_IO:     addr_cycles = CYC_ADDR_X2;
      OPC_DUAL_IO_DTR: addr_cycles = CYC_ADDR_X4;
      OPC_QUAD_IO:     addr_cycles = CYC_ADDR_X4;
      OPC_QUAD_IO_DTR: addr_cycles = CYC_ADDR_X8;
      OPC_FAST_DTR:    addr_cycles = qpi ? CYC_ADDR_X8 : CYC_ADDR_X2;
      default:         addr_cycles = qpi ? CYC_ADDR_X4 : CYC_ADDR_X1;
    endcase
  endfunction

  // Burst field to wrap length in bytes
  function automatic logic [6:0] burst_bytes(input logic [1:0] f);
    burst_bytes = 7'h08 << f;
  endfunction

endpackage

// >>> hw/sfrp_sync.sv
// Two-flop level synchroniser
module sfrp_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta;

  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// >>> hw/sfrp_pin_mux.sv
// Function selection for the shared hold/reset pin
module sfrp_pin_mux (
  // Mode inputs
  input  wire logic quad_lines_enable,
  input  wire logic qpi_mode,
  input  wire logic pin_function_select,
  input  wire logic ded_reset_present,
  input  wire logic ded_reset_disable,
  // Synchronised pin level, active low
  input  wire logic pin_level_n,
  // Resulting functions
  output logic      hold_req,
  output logic      reset_req,
  output logic      data_line_three,
  output logic      data_line_two
);

  logic quad_pins;
  logic pick_reset;

  // ==========================================================
  // Quad lines or QPI turn both pins into data
  assign quad_pins       = quad_lines_enable | qpi_mode;
  assign data_line_three = quad_pins;
  assign data_line_two   = quad_pins;

  // Live dedicated reset pin forces hold
  assign pick_reset = pin_function_select &
                      ~(ded_reset_present & ~ded_reset_disable);

  // Pin acts only when not a data line
  assign hold_req  = ~quad_pins & ~pick_reset & ~pin_level_n;
  assign reset_req = ~quad_pins & pick_reset & ~pin_level_n;

endmodule

// >>> hw/sfrp_read_params.sv
// Read-parameter register pair with serial command link
//
// Notes on behaviour
// - SPI, quad off: pin is hold when select bit 0, reset when 1.
// - Quad enable or QPI ignores select bit; pin is data line three.
// - Live dedicated reset pin forces hold function regardless of select.
// - Dummy count comes from bits 6..3; zero picks per-command default.
// - Nonzero dummy field gives that many dummy cycles, 1 to 15.
// - Burst field 00,01,10,11 selects 8,16,32,64 bytes.
// - Wrap bit 0 wraps at array end; 1 wraps at burst length.
// - 65h writes persistent copy; C0h or 63h writes working copy.
// - Default 8 dummies for SPI fast, dual and quad output; QPI 6.
// - Dual-I/O read defaults to 4 dummies, both rates.
// - Quad-I/O read defaults to 6 dummies, SPI and QPI, both rates.
// - Unique-ID and info-row reads use single fast read dummies.
// - Double-rate dual-I/O read is SPI only; refused in QPI.
// - All eight bits reset to zero.
// - At power-up the working copy loads from the persistent copy.
// - Quad enable makes protect and hold pins data lines two, three.
module sfrp_read_params (
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial link
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  // Device mode, from system-clock logic
  input  wire logic       quad_lines_enable,
  input  wire logic       qpi_mode,
  input  wire logic       ded_reset_present,
  input  wire logic       ded_reset_disable,
  // Shared hold/reset pin, active low
  input  wire logic       hold_reset_pin_n,
  // Register copies
  output logic [7:0]      read_params,
  output logic [7:0]      read_params_nv,
  // Decoded settings
  output logic [6:0]      burst_len,
  output logic            wrap_on_burst,
  output logic            hold_active,
  output logic            reset_active,
  output logic            io3_is_data,
  output logic            io2_is_data,
  output logic            load_done,
  // Link-side read status
  output logic [3:0]      dummy_count,
  output logic            data_phase,
  output logic            cmd_refused
);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SYS_LOAD = 2'b01,
    SYS_RUN  = 2'b10
  } sfrp_sys_t;

  typedef enum logic [5:0] {
    LK_OPC    = 6'b000001,
    LK_DATA   = 6'b000010,
    LK_ADDR   = 6'b000100,
    LK_DUMMY  = 6'b001000,
    LK_XFER   = 6'b010000,
    LK_IGNORE = 6'b100000
  } sfrp_link_t;

  // ==========================================================
  // System-side signals
  sfrp_sys_t  sys_state;
  logic       wr_tgl_sys;
  logic       wr_seen;
  logic       wr_event;
  logic [8:0] xfer_word;
  logic       xfer_tgl;
  logic       pin_low;
  logic       pin_level_n;
  logic       hold_req;
  logic       reset_req;
  logic       line3_req;
  logic       line2_req;

  // ==========================================================
  // Link-side signals
  sfrp_link_t lk_state;
  logic [5:0] lk_cnt;
  logic [7:0] lk_sr;
  logic [7:0] lk_opc;
  logic [7:0] next_sr;
  logic [5:0] byte_last;
  logic       byte_done;
  logic       lk_xfer_s;
  logic       lk_seen;
  logic [7:0] lk_params;
  logic       lk_qpi;
  logic [3:0] lk_dummy;
  logic [7:0] wr_data;
  logic       wr_nv;
  logic       wr_tgl;

  // ==========================================================
  // Crossings
  // Link write toggle into the system domain
  sfrp_sync u_wr_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (wr_tgl),
    .q     (wr_tgl_sys)
  );

  // Parameter-change toggle into the link domain
  sfrp_sync u_xfer_sync (
    .clk   (sck),
    .rst_n (rst_n),
    .d     (xfer_tgl),
    .q     (lk_xfer_s)
  );

  // Shared pin comes from outside, so it is synchronised; the
  // asserted level is carried so reset reads as an idle pin
  sfrp_sync u_pin_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (~hold_reset_pin_n),
    .q     (pin_low)
  );
  assign pin_level_n = ~pin_low;

  // ==========================================================
  // Pin function selection
  sfrp_pin_mux u_pin_mux (
    .quad_lines_enable   (quad_lines_enable),
    .qpi_mode            (qpi_mode),
    .pin_function_select (read_params[sfrp_pkg::PIN_SEL_BIT]),
    .ded_reset_present   (ded_reset_present),
    .ded_reset_disable   (ded_reset_disable),
    .pin_level_n         (pin_level_n),
    .hold_req            (hold_req),
    .reset_req           (reset_req),
    .data_line_three     (line3_req),
    .data_line_two       (line2_req)
  );

  // ==========================================================
  // System domain: write event detect
  assign wr_event = wr_tgl_sys ^ wr_seen;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen <= 1'b0;
    end else begin
      wr_seen <= wr_tgl_sys;
    end
  end

  // Power-up load sequence, one cycle after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_state <= SYS_LOAD;
      load_done <= 1'b0;
    end else begin
      case (sys_state)
        SYS_LOAD: begin
          sys_state <= SYS_RUN;
          load_done <= 1'b1;
        end
        SYS_RUN: sys_state <= SYS_RUN;
        default: sys_state <= SYS_LOAD;
      endcase
    end
  end

  // Persistent copy; a real part keeps it across power, here a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_params_nv <= sfrp_pkg::RP_RESET;
    end else if (wr_event && wr_nv) begin
      read_params_nv <= wr_data;
    end
  end

  // Working copy: loaded from persistent copy, then by commands.
  // wr_data is stable here: it only changes a whole frame later.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_params <= sfrp_pkg::RP_RESET;
    end else if (sys_state == SYS_LOAD) begin
      read_params <= read_params_nv;
    end else if (wr_event && !wr_nv) begin
      read_params <= wr_data;
    end
  end

  // Publish working copy and mode to the link with a toggle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_word <= {1'b0, sfrp_pkg::RP_RESET};
      xfer_tgl  <= 1'b0;
    end else if ({qpi_mode, read_params} != xfer_word) begin
      xfer_word <= {qpi_mode, read_params};
      xfer_tgl  <= ~xfer_tgl;
    end
  end

  // Decoded settings, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_len     <= sfrp_pkg::burst_bytes(2'h0);
      wrap_on_burst <= 1'b0;
    end else begin
      burst_len     <= sfrp_pkg::burst_bytes(
                       read_params[sfrp_pkg::BURST_MSB:
                                   sfrp_pkg::BURST_LSB]);
      wrap_on_burst <= read_params[sfrp_pkg::WRAP_BIT];
    end
  end

  // Pin functions, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_active  <= 1'b0;
      reset_active <= 1'b0;
      io3_is_data  <= 1'b0;
      io2_is_data  <= 1'b0;
    end else begin
      hold_active  <= hold_req;
      reset_active <= reset_req;
      io3_is_data  <= line3_req;
      io2_is_data  <= line2_req;
    end
  end

  // ==========================================================
  // Link domain: held copy of parameters.
  // Picked up on the third edge of a frame; the dummy count is
  // only fixed at address end, so a prior write always applies.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk_seen   <= 1'b0;
      lk_params <= sfrp_pkg::RP_RESET;
      lk_qpi    <= 1'b0;
    end else if (lk_xfer_s != lk_seen) begin
      lk_seen   <= lk_xfer_s;
      lk_params <= xfer_word[7:0];
      lk_qpi    <= xfer_word[8];
    end
  end

  // Shift one or four bits a period
  assign next_sr   = lk_qpi ? {lk_sr[3:0], io_in}
                            : {lk_sr[6:0], io_in[0]};
  assign byte_last = lk_qpi ? sfrp_pkg::CYC_BYTE_QPI
                            : sfrp_pkg::CYC_BYTE_SPI;
  assign byte_done = (lk_cnt + 6'h01) == byte_last;

  // Dummy count for the command in flight
  always_comb begin
    if (lk_params[sfrp_pkg::DUMMY_MSB:sfrp_pkg::DUMMY_LSB] == 4'h0) begin
      lk_dummy = sfrp_pkg::default_dummy(lk_opc, lk_qpi);
    end else begin
      lk_dummy = lk_params[sfrp_pkg::DUMMY_MSB:
                           sfrp_pkg::DUMMY_LSB];
    end
  end

  // Frame sequencer; chip select high clears it at once
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lk_state    <= LK_OPC;
      lk_cnt      <= 6'h00;
      lk_sr       <= 8'h00;
      lk_opc      <= 8'h00;
      dummy_count <= 4'h0;
      data_phase  <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      case (lk_state)
        LK_OPC: begin
          lk_sr  <= next_sr;
          lk_cnt <= lk_cnt + 6'h01;
          if (byte_done) begin
            lk_cnt <= 6'h00;
            lk_opc <= next_sr;
            if (next_sr == sfrp_pkg::OPC_SET_NV ||
                next_sr == sfrp_pkg::OPC_SET_VOL_A ||
                next_sr == sfrp_pkg::OPC_SET_VOL_B) begin
              lk_state <= LK_DATA;
            end else if (lk_qpi &&
                next_sr == sfrp_pkg::OPC_DUAL_IO_DTR) begin
              lk_state    <= LK_IGNORE;
              cmd_refused <= 1'b1;
            end else if (sfrp_pkg::is_read(next_sr)) begin
              lk_state <= LK_ADDR;
            end else begin
              lk_state <= LK_IGNORE;
            end
          end
        end
        LK_DATA: begin
          lk_sr  <= next_sr;
          lk_cnt <= lk_cnt + 6'h01;
          if (byte_done) begin
            lk_state <= LK_IGNORE;
          end
        end
        LK_ADDR: begin
          // Address periods are whole clocks at either rate
          lk_cnt <= lk_cnt + 6'h01;
          if ((lk_cnt + 6'h01) ==
              sfrp_pkg::addr_cycles(lk_opc, lk_qpi)) begin
            lk_cnt      <= 6'h00;
            lk_state    <= LK_DUMMY;
            dummy_count <= lk_dummy;
          end
        end
        LK_DUMMY: begin
          lk_cnt <= lk_cnt + 6'h01;
          if ((lk_cnt + 6'h01) == {2'h0, dummy_count}) begin
            lk_state   <= LK_XFER;
            data_phase <= 1'b1;
          end
        end
        LK_XFER:   lk_state <= LK_XFER;
        LK_IGNORE: lk_state <= LK_IGNORE;
        default:   lk_state <= LK_IGNORE;
      endcase
    end
  end

  // Completed set command handed to the system domain.
  // Only a whole data byte counts; a short frame writes nothing.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      wr_data <= sfrp_pkg::RP_RESET;
      wr_nv   <= 1'b0;
      wr_tgl  <= 1'b0;
    end else if (!cs_n && lk_state == LK_DATA && byte_done) begin
      wr_data <= next_sr;
      wr_nv   <= (lk_opc == sfrp_pkg::OPC_SET_NV);
      wr_tgl  <= ~wr_tgl;
    end
  end

endmodule

// >>> testbench/sfrp_read_params_properties.sv
// Concurrent checks on the ports of the read-parameter block
module sfrp_read_params_props (
  // Clocks and reset
  input logic       sys_clk,
  input logic       rst_n,
  input logic       sck,
  // Link and device modes
  input logic       cs_n,
  input logic [3:0] io_in,
  input logic       quad_lines_enable,
  input logic       qpi_mode,
  input logic       ded_reset_present,
  input logic       ded_reset_disable,
  input logic       hold_reset_pin_n,
  // Outputs under watch
  input logic [7:0] read_params,
  input logic [7:0] read_params_nv,
  input logic [6:0] burst_len,
  input logic       wrap_on_burst,
  input logic       hold_active,
  input logic       reset_active,
  input logic       io3_is_data,
  input logic       io2_is_data,
  input logic       load_done,
  input logic [3:0] dummy_count,
  input logic       data_phase,
  input logic       cmd_refused
);
  // ==========================================================
  // Helper state
  // Periods since the dummy count was set; saturates so it never wraps
  logic [4:0] dum_cnt;
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n) dum_cnt <= 5'h00;
    else if (dummy_count == 4'h0) dum_cnt <= 5'h00;
    else if (dum_cnt != 5'h1F) dum_cnt <= dum_cnt + 5'h01;
  end
  // Mode terms shared by the pin checks
  wire spi_plain = !quad_lines_enable && !qpi_mode;
  wire ded_live  = ded_reset_present && !ded_reset_disable;

  // ==========================================================
  // System-clock properties
  sequence s_quad_on;
    (quad_lines_enable || qpi_mode) [*3];
  endsequence
  property p_burst;
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> burst_len == (7'h08 << $past(read_params[1:0])) &&
             wrap_on_burst == $past(read_params[2]);
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst decode mismatch");
  property p_nv_alone;
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(read_params_nv) |-> $stable(read_params);
  endproperty
  a_nv_alone: assert property (p_nv_alone)
    else $error("persistent write touched working copy");
  property p_vol_alone;
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(read_params) |-> $stable(read_params_nv);
  endproperty
  a_vol_alone: assert property (p_vol_alone)
    else $error("working write touched persistent copy");
  property p_load;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(load_done) |-> read_params == read_params_nv;
  endproperty
  a_load: assert property (p_load)
    else $error("working copy not loaded");
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (spi_plain && !hold_reset_pin_n && (!read_params[7] || ded_live)) [*5]
    |-> hold_active && !reset_active;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold function not selected");
  property p_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    (spi_plain && !hold_reset_pin_n && read_params[7] && !ded_live) [*5]
    |-> reset_active && !hold_active;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset function not selected");
  property p_quad;
    @(posedge sys_clk) disable iff (!rst_n)
    s_quad_on |-> io3_is_data && !hold_active && !reset_active;
  endproperty
  a_quad: assert property (p_quad)
    else $error("shared pin not a data line");
  property p_io2;
    @(posedge sys_clk) disable iff (!rst_n)
    quad_lines_enable [*3] |-> io2_is_data;
  endproperty
  a_io2: assert property (p_io2)
    else $error("protect pin not a data line");

  // ==========================================================
  // Link-clock properties
  property p_dummy_len;
    @(posedge sck) disable iff (!rst_n || cs_n)
    $rose(data_phase) |-> dum_cnt == {1'b0, dummy_count};
  endproperty
  a_dummy_len: assert property (p_dummy_len)
    else $error("dummy period count wrong");
  property p_refuse;
    @(posedge sck) disable iff (!rst_n || cs_n)
    cmd_refused |-> !data_phase && dummy_count == 4'h0;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused read ran dummies");
endmodule

bind sfrp_read_params sfrp_read_params_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
  .io_in(io_in), .quad_lines_enable(quad_lines_enable),
  .qpi_mode(qpi_mode), .ded_reset_present(ded_reset_present),
  .ded_reset_disable(ded_reset_disable),
  .hold_reset_pin_n(hold_reset_pin_n), .read_params(read_params),
  .read_params_nv(read_params_nv), .burst_len(burst_len),
  .wrap_on_burst(wrap_on_burst), .hold_active(hold_active),
  .reset_active(reset_active), .io3_is_data(io3_is_data),
  .io2_is_data(io2_is_data), .load_done(load_done),
  .dummy_count(dummy_count), .data_phase(data_phase),
  .cmd_refused(cmd_refused)
);

// >>> testbench/sfrp_host.sv
// Host model driving the serial link of the read-parameter block
module sfrp_host (
  // Link to the device
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle link: clock parked low, lines never hold a stale value
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b0;
    io_in = 4'hA;
    // A rising select after time zero clears the frame logic
    #1 cs_n = 1'b1;
  end

  // Periods of 32 ns stay under every read clock limit
  task automatic shift(input logic [31:0] v, input int n, input bit q);
    for (int i = 0; i < n; i++) begin
      io_in = q ? v[31:28] : {4{v[31]}};
      v = q ? v << 4 : v << 1;
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
  endtask

  // Opcode MSB first; QPI sends two nibbles
  task automatic start(input logic [7:0] op, input bit q);
    cs_n = 1'b0;
    #16;
    shift({op, 24'h0}, q ? 2 : 8, q);
  endtask

  // Release inverts the lines so a stale level cannot pass
  task automatic stop();
    #16 cs_n = 1'b1;
    io_in = ~io_in;
    #32;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the read-parameter register block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_count++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end

  // ==========================================================
  // Signals
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b1;
  logic       sck, cs_n;
  logic [3:0] io_in;
  logic       quad_lines_enable = 1'b0;
  logic       qpi_mode = 1'b0;
  logic       ded_reset_present = 1'b0;
  logic       ded_reset_disable = 1'b0;
  logic       hold_reset_pin_n = 1'b1;
  logic [7:0] read_params, read_params_nv;
  logic [6:0] burst_len;
  logic       wrap_on_burst, hold_active, reset_active, load_done;
  logic       io3_is_data, io2_is_data, data_phase, cmd_refused;
  logic [3:0] dummy_count;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // Read opcodes, SPI address periods and default dummies
  logic [7:0] ops [10] = '{8'h0B, 8'h0D, 8'h3B, 8'hBB, 8'hBD,
                           8'h6B, 8'hEB, 8'hED, 8'h4B, 8'h68};
  int         aps [10] = '{24, 12, 24, 12, 6, 24, 6, 3, 24, 24};
  logic [3:0] dfs [10] = '{8, 8, 8, 4, 4, 8, 6, 6, 8, 8};
  logic [7:0] qops [6] = '{8'h0B, 8'h0D, 8'hEB, 8'hED, 8'h4B, 8'h68};
  logic [3:0] fs [3]   = '{4'h0, 4'h1, 4'hF};

  always #2.5 sys_clk = ~sys_clk;

  // ==========================================================
  // Device and host
  sfrp_read_params dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .quad_lines_enable(quad_lines_enable),
    .qpi_mode(qpi_mode), .ded_reset_present(ded_reset_present),
    .ded_reset_disable(ded_reset_disable),
    .hold_reset_pin_n(hold_reset_pin_n), .read_params(read_params),
    .read_params_nv(read_params_nv), .burst_len(burst_len),
    .wrap_on_burst(wrap_on_burst), .hold_active(hold_active),
    .reset_active(reset_active), .io3_is_data(io3_is_data),
    .io2_is_data(io2_is_data), .load_done(load_done),
    .dummy_count(dummy_count), .data_phase(data_phase),
    .cmd_refused(cmd_refused)
  );
  sfrp_host host (.sck(sck), .cs_n(cs_n), .io_in(io_in));

  // ==========================================================
  // Tasks
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Set command with one data byte, then let the write cross over
  task automatic setp(input logic [7:0] op, input logic [7:0] v,
                      input bit q);
    host.start(op, q);
    host.shift({v, 24'h0}, q ? 2 : 8, q);
    host.stop();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // Idle frame: the link takes a new mode or copy on a frame's third
  // edge, and two changes with no frame between would cancel
  task automatic flush();
    host.start(8'h00, 1'b0);
    host.stop();
  endtask

  // Read up to one period short of data, then across the boundary
  task automatic rd(input logic [7:0] op, input int ap,
                    input logic [3:0] d, input bit q);
    host.start(op, q);
    host.shift(32'h0, ap + d - 1, q);
    `CHK(dummy_count, d)
    `CHK(data_phase, 1'b0)
    host.shift(32'h0, 1, q);
    `CHK(data_phase, 1'b1)
    host.shift(32'h0, 1, q);
    host.stop();
  endtask

  // Modes {quad, qpi, present, disable}; expect {hold, reset, io3}
  task automatic pin(input logic [3:0] m, input logic [2:0] e);
    @(posedge sys_clk);
    {quad_lines_enable, qpi_mode, ded_reset_present,
     ded_reset_disable} <= m;
    hold_reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK({hold_active, reset_active, io3_is_data}, e)
    if (m[3]) `CHK(io2_is_data, 1'b1)
    @(posedge sys_clk);
    hold_reset_pin_n <= 1'b1;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    // Falling edge by nonblocking write at time zero so every flop sees the reset
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({read_params, read_params_nv}, 16'h0000)
    `CHK({wrap_on_burst, burst_len}, 8'h08)
    `CHK(load_done, 1'b1)
    setp(8'h65, 8'h5A, 1'b0);
    `CHK({read_params_nv, read_params}, 16'h5A00)
    // Every burst code, through both working-copy opcodes
    for (int b = 0; b < 4; b++) begin
      setp(b[0] ? 8'hC0 : 8'h63, {6'h01, b[1:0]}, 1'b0);
      `CHK(burst_len, 7'h08 << b[1:0])
      `CHK(wrap_on_burst, 1'b1)
    end
    setp(8'h63, 8'h03, 1'b0);
    `CHK({wrap_on_burst, read_params_nv}, 9'h05A)
    // Every SPI read, default and programmed dummies
    foreach (fs[k]) begin
      setp(8'h63, {1'b0, fs[k], 3'h0}, 1'b0);
      foreach (ops[i])
        rd(ops[i], aps[i], fs[k] != 4'h0 ? fs[k] : dfs[i], 1'b0);
    end
    // QPI reads; set data goes high nibble first
    @(posedge sys_clk);
    qpi_mode <= 1'b1;
    repeat (20) @(posedge sys_clk);
    flush();
    foreach (fs[k]) begin
      setp(8'h63, {1'b0, fs[k], 3'h0}, 1'b1);
      `CHK(read_params, {1'b0, fs[k], 3'h0})
      foreach (qops[i])
        rd(qops[i], (qops[i] == 8'h0D || qops[i] == 8'hED) ? 3 : 6,
           fs[k] != 4'h0 ? fs[k] : 4'h6, 1'b1);
    end
    host.start(8'hBD, 1'b1);
    host.shift(32'h0, 16, 1'b1);
    `CHK({cmd_refused, data_phase, dummy_count}, 6'h20)
    host.stop();
    setp(8'h63, 8'h00, 1'b1);
    flush();
    @(posedge sys_clk);
    qpi_mode <= 1'b0;
    repeat (20) @(posedge sys_clk);
    flush();
    // Shared pin function in each mode
    pin(4'b0000, 3'b100);
    setp(8'h63, 8'h80, 1'b0);
    pin(4'b0000, 3'b010);
    pin(4'b0010, 3'b100);
    pin(4'b0011, 3'b010);
    pin(4'b1000, 3'b001);
    pin(4'b0100, 3'b001);
    test_done();
  end
endmodule
